//--- include/fle_pkg.sv
// Constants and types for the flag, move and load execution block
package fle_pkg;
  localparam int FLE_NREG = 32;
  localparam int FLE_DW = 8;
  localparam int FLE_AW = 16;
  localparam int FLE_RW = 5;
  localparam int FLE_QW = 6;
  // Bit positions inside the flag word register
  localparam logic [2:0] FLE_FLAG_C = 3'h0;
  localparam logic [2:0] FLE_FLAG_Z = 3'h1;
  localparam logic [2:0] FLE_FLAG_N = 3'h2;
  localparam logic [2:0] FLE_FLAG_V = 3'h3;
  localparam logic [2:0] FLE_FLAG_S = 3'h4;
  localparam logic [2:0] FLE_FLAG_H = 3'h5;
  localparam logic [2:0] FLE_FLAG_T = 3'h6;
  localparam logic [2:0] FLE_FLAG_I = 3'h7;
  localparam logic [7:0] FLE_FLAG_RESET = 8'h00;
  localparam logic [7:0] FLE_REG_RESET = 8'h00;
  // Opcode patterns, compared after masking
  localparam logic [15:0] FLE_FLAG_MASK = 16'hFF8F;
  localparam logic [15:0] FLE_OP_BSET = 16'h9408;
  localparam logic [15:0] FLE_OP_BCLR = 16'h9488;
  localparam logic [15:0] FLE_MOV_MASK = 16'hFC00;
  localparam logic [15:0] FLE_OP_MOV = 16'h2C00;
  localparam logic [15:0] FLE_MOVW_MASK = 16'hFF00;
  localparam logic [15:0] FLE_OP_MOVW = 16'h0100;
  localparam logic [15:0] FLE_LDST_MASK = 16'hFC00;
  localparam logic [15:0] FLE_OP_LDST = 16'h9000;
  localparam logic [15:0] FLE_LDD_MASK = 16'hD000;
  localparam logic [15:0] FLE_OP_LDD = 16'h8000;
  // Field positions
  localparam int FLE_D_LSB = 4;
  localparam int FLE_R_LSB = 0;
  localparam int FLE_R4_BIT = 9;
  localparam int FLE_S_LSB = 4;
  localparam int FLE_WD_LSB = 4;
  localparam int FLE_WR_LSB = 0;
  localparam int FLE_STORE_BIT = 9;
  localparam int FLE_NIB_LSB = 0;
  localparam int FLE_YZ_BIT = 3;
  localparam int FLE_Q5_BIT = 13;
  localparam int FLE_Q43_LSB = 10;
  localparam int FLE_Q20_LSB = 0;
  // Low nibble codes of the indirect and direct group
  localparam logic [3:0] FLE_NIB_DIRECT = 4'h0;
  localparam logic [3:0] FLE_NIB_ZINC = 4'h1;
  localparam logic [3:0] FLE_NIB_ZDEC = 4'h2;
  localparam logic [3:0] FLE_NIB_YINC = 4'h9;
  localparam logic [3:0] FLE_NIB_YDEC = 4'hA;
  localparam logic [3:0] FLE_NIB_X = 4'hC;
  localparam logic [3:0] FLE_NIB_XINC = 4'hD;
  localparam logic [3:0] FLE_NIB_XDEC = 4'hE;
  // Low registers of the three pointer pairs
  localparam logic [4:0] FLE_X_LO = 5'h1A;
  localparam logic [4:0] FLE_Y_LO = 5'h1C;
  localparam logic [4:0] FLE_Z_LO = 5'h1E;
  localparam logic [15:0] FLE_PTR_STEP = 16'h0001;
  localparam logic [5:0] FLE_DISP_NONE = 6'h00;

  typedef enum {
    FLE_PM_PLAIN, FLE_PM_POSTINC, FLE_PM_PREDEC, FLE_PM_DISP, FLE_PM_DIRECT
  } fle_pmode_t;

  typedef enum {FLE_ST_IDLE, FLE_ST_MEM} fle_state_t;
endpackage : fle_pkg

//--- include/fle_agu_if.sv
// Address generation signals between the core and its address unit
interface fle_agu_if;
  import fle_pkg::*;
  fle_pmode_t mode;
  logic [15:0] ptr;
  logic [15:0] direct;
  logic [5:0] disp;
  logic [15:0] addr;
  logic [15:0] new_ptr;
  logic ptr_wr;
  modport core (output mode, output ptr, output direct, output disp,
                input addr, input new_ptr, input ptr_wr);
  modport agu (input mode, input ptr, input direct, input disp,
               output addr, output new_ptr, output ptr_wr);
endinterface : fle_agu_if

//--- core/fle_agu.sv
// Effective address and pointer update for data memory accesses
module fle_agu
  import fle_pkg::*;
(
  fle_agu_if.agu agu
);
  always_comb begin
    agu.addr = agu.ptr;
    agu.new_ptr = agu.ptr;
    agu.ptr_wr = 1'b0;
    case (agu.mode)
      FLE_PM_PLAIN: begin
        agu.addr = agu.ptr;
      end
      FLE_PM_POSTINC: begin
        agu.addr = agu.ptr;
        agu.new_ptr = agu.ptr + FLE_PTR_STEP;
        agu.ptr_wr = 1'b1;
      end
      FLE_PM_PREDEC: begin
        agu.new_ptr = agu.ptr - FLE_PTR_STEP;
        agu.addr = agu.new_ptr;
        agu.ptr_wr = 1'b1;
      end
      FLE_PM_DISP: begin
        agu.addr = agu.ptr + {10'h000, agu.disp};
      end
      FLE_PM_DIRECT: begin
        agu.addr = agu.direct;
      end
      default: begin
        agu.addr = agu.ptr;
      end
    endcase
  end
endmodule // fle_agu

//--- core/fle_exec.sv
// Executes flag set/clear, register moves and data memory loads
module fle_exec
  import fle_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Instruction stream
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] instr_ext_in,
  output logic instr_ready_out,
  output logic done_out,
  output logic illegal_out,
  // Data memory bus
  output logic [15:0] dmem_addr_out,
  output logic dmem_rd_out,
  output logic dmem_wr_out,
  output logic [7:0] dmem_wdata_out,
  input wire logic [7:0] dmem_rdata_in,
  // Status and register view
  output logic [7:0] flag_word_register_out,
  input wire logic [4:0] dbg_sel_in,
  output logic [7:0] dbg_reg_out
);
  logic [7:0] regs [FLE_NREG];
  logic [7:0] flags;
  fle_state_t state;
  logic [4:0] pend_dst;
  logic pend_ld;
  logic acc;
  logic dec_flag, dec_set, dec_mov, dec_movw, dec_mem, dec_store;
  logic dec_illegal;
  logic [2:0] dec_bit;
  logic [4:0] dec_d, dec_r, dec_wd, dec_wr, dec_psel;
  logic [5:0] dec_disp;
  fle_pmode_t dec_mode;
  logic [7:0] src_val;
  logic [15:0] cur_ptr;

  fle_agu_if agu_bus ();
  fle_agu u_agu (
    .agu(agu_bus.agu)
  );

  assign acc = instr_valid_in & instr_ready_out;
  assign dec_d = instr_in[FLE_D_LSB +: FLE_RW];
  assign dec_r = {instr_in[FLE_R4_BIT], instr_in[FLE_R_LSB +: 4]};
  assign dec_wd = {instr_in[FLE_WD_LSB +: 4], 1'b0};
  assign dec_wr = {instr_in[FLE_WR_LSB +: 4], 1'b0};
  assign dec_bit = instr_in[FLE_S_LSB +: 3];
  assign src_val = regs[dec_r];
  assign cur_ptr = {regs[{dec_psel[4:1], 1'b1}], regs[dec_psel]};
  assign dec_illegal = !(dec_flag | dec_mov | dec_movw | dec_mem);
  assign agu_bus.mode = dec_mode;
  assign agu_bus.ptr = cur_ptr;
  assign agu_bus.direct = instr_ext_in;
  assign agu_bus.disp = dec_disp;

  // Instruction decode
  always_comb begin
    dec_flag = 1'b0;
    dec_set = 1'b0;
    dec_mov = 1'b0;
    dec_movw = 1'b0;
    dec_mem = 1'b0;
    dec_store = 1'b0;
    dec_mode = FLE_PM_PLAIN;
    dec_psel = FLE_X_LO;
    dec_disp = FLE_DISP_NONE;
    if ((instr_in & FLE_FLAG_MASK) == FLE_OP_BSET) begin
      dec_flag = 1'b1;
      dec_set = 1'b1;
    end else if ((instr_in & FLE_FLAG_MASK) == FLE_OP_BCLR) begin
      dec_flag = 1'b1;
    end else if ((instr_in & FLE_MOV_MASK) == FLE_OP_MOV) begin
      dec_mov = 1'b1;
    end else if ((instr_in & FLE_MOVW_MASK) == FLE_OP_MOVW) begin
      dec_movw = 1'b1;
    end else if ((instr_in & FLE_LDST_MASK) == FLE_OP_LDST) begin
      dec_store = instr_in[FLE_STORE_BIT];
      case (instr_in[FLE_NIB_LSB +: 4])
        FLE_NIB_DIRECT: begin
          dec_mem = !dec_store;
          dec_mode = FLE_PM_DIRECT;
        end
        FLE_NIB_ZINC: begin
          dec_mem = !dec_store;
          dec_mode = FLE_PM_POSTINC;
          dec_psel = FLE_Z_LO;
        end
        FLE_NIB_ZDEC: begin
          dec_mem = !dec_store;
          dec_mode = FLE_PM_PREDEC;
          dec_psel = FLE_Z_LO;
        end
        FLE_NIB_YINC: begin
          dec_mem = !dec_store;
          dec_mode = FLE_PM_POSTINC;
          dec_psel = FLE_Y_LO;
        end
        FLE_NIB_YDEC: begin
          dec_mem = !dec_store;
          dec_mode = FLE_PM_PREDEC;
          dec_psel = FLE_Y_LO;
        end
        FLE_NIB_X: begin
          dec_mem = 1'b1;
        end
        FLE_NIB_XINC: begin
          dec_mem = !dec_store;
          dec_mode = FLE_PM_POSTINC;
        end
        FLE_NIB_XDEC: begin
          dec_mem = !dec_store;
          dec_mode = FLE_PM_PREDEC;
        end
        default: begin
          dec_mem = 1'b0;
        end
      endcase
    end else if ((instr_in & FLE_LDD_MASK) == FLE_OP_LDD) begin
      dec_store = instr_in[FLE_STORE_BIT];
      dec_disp = {instr_in[FLE_Q5_BIT], instr_in[FLE_Q43_LSB +: 2],
                  instr_in[FLE_Q20_LSB +: 3]};
      dec_psel = instr_in[FLE_YZ_BIT] ? FLE_Y_LO : FLE_Z_LO;
      // Stores with a nonzero offset belong to another block
      if (dec_disp == FLE_DISP_NONE) begin
        dec_mem = 1'b1;
      end else begin
        dec_mem = !dec_store;
        dec_mode = FLE_PM_DISP;
      end
    end
  end

  // Register file writes
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < FLE_NREG; i++) begin
        regs[i] <= FLE_REG_RESET;
      end
    end else if (state == FLE_ST_MEM) begin
      if (pend_ld) begin
        regs[pend_dst] <= dmem_rdata_in;
      end
    end else if (acc) begin
      if (dec_mov) begin
        regs[dec_d] <= src_val;
      end
      if (dec_movw) begin
        regs[dec_wd] <= regs[dec_wr];
        regs[{dec_wd[4:1], 1'b1}] <= regs[{dec_wr[4:1], 1'b1}];
      end
      if (dec_mem && agu_bus.ptr_wr) begin
        regs[dec_psel] <= agu_bus.new_ptr[7:0];
        regs[{dec_psel[4:1], 1'b1}] <= agu_bus.new_ptr[15:8];
      end
    end
  end

  // Flag word register; only the addressed bit changes
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags <= FLE_FLAG_RESET;
    end else if (acc && dec_flag) begin
      flags[dec_bit] <= dec_set;
    end
  end

  // Sequencing and data memory bus
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= FLE_ST_IDLE;
      instr_ready_out <= 1'b0;
      dmem_addr_out <= 16'h0000;
      dmem_rd_out <= 1'b0;
      dmem_wr_out <= 1'b0;
      dmem_wdata_out <= 8'h00;
      pend_dst <= 5'h00;
      pend_ld <= 1'b0;
    end else if (state == FLE_ST_MEM) begin
      state <= FLE_ST_IDLE;
      instr_ready_out <= 1'b1;
      dmem_rd_out <= 1'b0;
      dmem_wr_out <= 1'b0;
    end else begin
      instr_ready_out <= 1'b1;
      if (acc && dec_mem) begin
        state <= FLE_ST_MEM;
        instr_ready_out <= 1'b0;
        dmem_addr_out <= agu_bus.addr;
        dmem_rd_out <= !dec_store;
        dmem_wr_out <= dec_store;
        dmem_wdata_out <= regs[dec_d];
        pend_dst <= dec_d;
        pend_ld <= !dec_store;
      end
    end
  end

  // Completion and status outputs
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
      illegal_out <= 1'b0;
      flag_word_register_out <= FLE_FLAG_RESET;
      dbg_reg_out <= FLE_REG_RESET;
    end else begin
      done_out <= (state == FLE_ST_MEM) ||
                  (acc && (dec_flag || dec_mov || dec_movw));
      illegal_out <= acc && dec_illegal;
      flag_word_register_out <= flags;
      dbg_reg_out <= regs[dbg_sel_in];
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  sequence mem_issue_s;
    !instr_ready_out && (dmem_rd_out || dmem_wr_out);
  endsequence
  sequence mem_retire_s;
    done_out && instr_ready_out && !dmem_rd_out && !dmem_wr_out;
  endsequence

  half_carry_a: assert property (
    acc && dec_flag && dec_bit == FLE_FLAG_H |=>
      flags[FLE_FLAG_H] == $past(dec_set) && done_out)
    else $error("half-carry flag not forced");
  overflow_flag_a: assert property (
    acc && dec_flag && dec_bit == FLE_FLAG_V |=>
      flags[FLE_FLAG_V] == $past(dec_set))
    else $error("overflow flag not forced");
  signed_flag_a: assert property (
    acc && dec_flag && dec_bit == FLE_FLAG_S |=>
      flags[FLE_FLAG_S] == $past(dec_set))
    else $error("signed-test flag not forced");
  flag_only_a: assert property (
    acc && dec_flag |=>
      ((flags ^ $past(flags)) & ~(8'h01 << $past(dec_bit))) == 8'h00)
    else $error("flag instruction touched another flag");
  byte_move_a: assert property (
    acc && dec_mov |=> regs[$past(dec_d)] == $past(src_val) &&
      $stable(flags) && done_out)
    else $error("register move wrong");
  word_move_a: assert property (
    acc && dec_movw |=>
      regs[{$past(dec_wd[4:1]), 1'b1}] ==
        $past(regs[{dec_wr[4:1], 1'b1}]) &&
      regs[$past(dec_wd)] == $past(regs[dec_wr]))
    else $error("word move wrong");
  post_inc_a: assert property (
    acc && dec_mem && dec_mode == FLE_PM_POSTINC |=>
      dmem_addr_out == $past(cur_ptr) &&
      {regs[{$past(dec_psel[4:1]), 1'b1}], regs[$past(dec_psel)]} ==
        $past(cur_ptr) + FLE_PTR_STEP)
    else $error("post-increment address or pointer wrong");
  pre_dec_a: assert property (
    acc && dec_mem && dec_mode == FLE_PM_PREDEC |=>
      dmem_addr_out == $past(cur_ptr) - FLE_PTR_STEP)
    else $error("pre-decrement address wrong");
  disp_load_a: assert property (
    acc && dec_mem && dec_mode == FLE_PM_DISP |=>
      dmem_addr_out == $past(cur_ptr) + {10'h000, $past(dec_disp)} &&
      {regs[{$past(dec_psel[4:1]), 1'b1}], regs[$past(dec_psel)]} ==
        $past(cur_ptr))
    else $error("displacement address or pointer wrong");
  direct_load_a: assert property (
    acc && dec_mem && dec_mode == FLE_PM_DIRECT |=>
      dmem_addr_out == $past(instr_ext_in) && dmem_rd_out)
    else $error("direct load address wrong");
  two_cycle_a: assert property (
    acc && dec_mem |=> mem_issue_s ##1 mem_retire_s)
    else $error("memory access not two cycles");
  load_data_a: assert property (
    dmem_rd_out |=> regs[$past(pend_dst)] == $past(dmem_rdata_in))
    else $error("loaded byte not written");
  mem_flags_a: assert property (
    acc && dec_mem |=> $stable(flags) [*2])
    else $error("memory access changed a flag");
endmodule // fle_exec

//--- sim/fle_dmem_model.sv
// Data memory model answering the block's one-cycle read and write strobes
module fle_dmem_model
  import fle_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Access request
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  // Read answer
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] last;

  initial begin
    last = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end

  // Outside a read the bus shows the inverse of the last byte, never stale data
  always_comb begin
    rdata_out = rd_in ? mem[addr_in[7:0]] : ~last;
  end

  always @(posedge mclk_in) begin
    if (wr_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
    if (rd_in) begin
      last <= rdata_out;
    end
  end
endmodule // fle_dmem_model

//--- sim/flag_and_load_exec_tb.sv
// Self-checking testbench for the flag, move and load execution block
module flag_and_load_exec_tb
  import fle_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic [15:0] instr_ext_in = 16'h0000;
  logic [4:0] dbg_sel_in = 5'h00;
  logic instr_ready_out;
  logic done_out;
  logic illegal_out;
  logic [15:0] dmem_addr_out;
  logic dmem_rd_out;
  logic dmem_wr_out;
  logic [7:0] dmem_wdata_out;
  logic [7:0] dmem_rdata_in;
  logic [7:0] flag_word_register_out;
  logic [7:0] dbg_reg_out;
  int n_errors = 0;
  int checks_done = 0;

  always #5 mclk_in = ~mclk_in;

  fle_exec fle_exec_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .instr_ext_in(instr_ext_in), .instr_ready_out(instr_ready_out),
    .done_out(done_out), .illegal_out(illegal_out),
    .dmem_addr_out(dmem_addr_out), .dmem_rd_out(dmem_rd_out),
    .dmem_wr_out(dmem_wr_out), .dmem_wdata_out(dmem_wdata_out),
    .dmem_rdata_in(dmem_rdata_in),
    .flag_word_register_out(flag_word_register_out),
    .dbg_sel_in(dbg_sel_in), .dbg_reg_out(dbg_reg_out)
  );

  fle_dmem_model fle_dmem_model_i (
    .mclk_in(mclk_in), .addr_in(dmem_addr_out), .rd_in(dmem_rd_out),
    .wr_in(dmem_wr_out), .wdata_in(dmem_wdata_out),
    .rdata_out(dmem_rdata_in)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Offers one instruction and returns at the negedge of the answer cycle
  task automatic issue(input logic [15:0] w, input logic [15:0] x);
    int i;
    i = 0;
    @(negedge mclk_in);
    while (instr_ready_out !== 1'b1 && i < 20) begin
      @(negedge mclk_in);
      i++;
    end
    chk(16'(instr_ready_out), 16'h0001);
    @(posedge mclk_in);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    instr_ext_in <= x;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    @(negedge mclk_in);
  endtask

  task automatic op1(input logic [15:0] w, input logic [7:0] fl);
    issue(w, 16'h0000);
    chk(16'(done_out), 16'h0001);
    @(negedge mclk_in);
    chk(16'(flag_word_register_out), 16'(fl));
  endtask

  task automatic mop(input logic [15:0] w, input logic [15:0] x,
                     input logic [15:0] ea, input logic wr,
                     input logic [7:0] wd);
    issue(w, x);
    chk(dmem_addr_out, ea);
    chk(16'({dmem_rd_out, dmem_wr_out}), 16'({~wr, wr}));
    if (wr) begin
      chk(16'(dmem_wdata_out), 16'(wd));
    end
    chk(16'(instr_ready_out), 16'h0000);
    @(negedge mclk_in);
    chk(16'(done_out), 16'h0001);
    chk(16'(instr_ready_out), 16'h0001);
  endtask

  // Refused opcode: one illegal pulse, no completion, no bus access
  task automatic bad(input logic [15:0] w);
    issue(w, 16'h0040);
    chk(16'({illegal_out, done_out}), 16'h0002);
    chk(16'({dmem_rd_out, dmem_wr_out}), 16'h0000);
    @(negedge mclk_in);
    chk(16'(illegal_out), 16'h0000);
  endtask

  task automatic reg_is(input logic [4:0] r, input logic [7:0] v);
    @(posedge mclk_in);
    dbg_sel_in <= r;
    @(posedge mclk_in);
    @(negedge mclk_in);
    chk(16'(dbg_reg_out), 16'(v));
  endtask

  // Every flag set one at a time, then cleared one at a time
  task automatic t_flags();
    logic [7:0] e;
    e = 8'h00;
    for (int s = 0; s < 8; s++) begin
      e[s] = 1'b1;
      op1(FLE_OP_BSET | (16'(s) << 4), e);
    end
    for (int s = 0; s < 8; s++) begin
      e[s] = 1'b0;
      op1(FLE_OP_BCLR | (16'(s) << 4), e);
    end
    $display("test flags done");
  endtask

  // Loads in every addressing mode and a store read back
  task automatic t_mem();
    op1(FLE_OP_BSET | 16'h0050, 8'h20);
    op1(FLE_OP_BSET | 16'h0030, 8'h28);
    mop(16'h91A0, 16'h0040, 16'h0040, 1'b0, 8'h00);
    reg_is(5'd26, 8'hE5);
    mop(16'h901C, 16'h0000, 16'h00E5, 1'b0, 8'h00);
    reg_is(5'd1, 8'h40);
    reg_is(5'd26, 8'hE5);
    mop(16'h902D, 16'h0000, 16'h00E5, 1'b0, 8'h00);
    reg_is(5'd2, 8'h40);
    reg_is(5'd26, 8'hE6);
    mop(16'h903E, 16'h0000, 16'h00E5, 1'b0, 8'h00);
    reg_is(5'd3, 8'h40);
    reg_is(5'd26, 8'hE5);
    mop(16'h91C0, 16'h0020, 16'h0020, 1'b0, 8'h00);
    mop(16'hAC4F, 16'h0000, 16'h00C4, 1'b0, 8'h00);
    reg_is(5'd4, 8'h61);
    reg_is(5'd28, 8'h85);
    mop(16'h9089, 16'h0000, 16'h0085, 1'b0, 8'h00);
    reg_is(5'd8, 8'h20);
    mop(16'h909A, 16'h0000, 16'h0085, 1'b0, 8'h00);
    reg_is(5'd28, 8'h85);
    mop(16'h91E0, 16'h0030, 16'h0030, 1'b0, 8'h00);
    mop(16'h9051, 16'h0000, 16'h0095, 1'b0, 8'h00);
    reg_is(5'd5, 8'h30);
    mop(16'h8071, 16'h0000, 16'h0097, 1'b0, 8'h00);
    reg_is(5'd7, 8'h32);
    reg_is(5'd30, 8'h96);
    mop(16'h9062, 16'h0000, 16'h0095, 1'b0, 8'h00);
    reg_is(5'd30, 8'h95);
    mop(16'h924C, 16'h0000, 16'h00E5, 1'b1, 8'h61);
    mop(16'h90AC, 16'h0000, 16'h00E5, 1'b0, 8'h00);
    reg_is(5'd10, 8'h61);
    chk(16'(flag_word_register_out), 16'h0028);
    $display("test loads done");
  endtask

  // Byte moves from low and high sources, then a word move
  task automatic t_moves();
    op1(16'h2CB7, 8'h28);
    reg_is(5'd11, 8'h32);
    op1(16'h2ECA, 8'h28);
    reg_is(5'd12, 8'hE5);
    op1(16'h0172, 8'h28);
    reg_is(5'd14, 8'h61);
    reg_is(5'd15, 8'h30);
    $display("test moves done");
  endtask

  // Plain store and load through Y, then refused opcodes leave state alone
  task automatic t_refused();
    mop(16'h82C8, 16'h0000, 16'h0085, 1'b1, 8'hE5);
    mop(16'h80D8, 16'h0000, 16'h0085, 1'b0, 8'h00);
    reg_is(5'd13, 8'hE5);
    reg_is(5'd28, 8'h85);
    bad(16'h9200);
    bad(16'h924D);
    bad(16'h8209);
    reg_is(5'd26, 8'hE5);
    mop(16'h9100, 16'h0040, 16'h0040, 1'b0, 8'h00);
    reg_is(5'd16, 8'hE5);
    chk(16'(flag_word_register_out), 16'h0028);
    $display("test refused done");
  endtask

  initial begin
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_flags();
    t_mem();
    t_moves();
    t_refused();
    complete_run();
  end

  initial begin
    #50000;
    n_errors++;
    complete_run();
  end
endmodule // flag_and_load_exec_tb
